// >>> src/sdr_top.sv
// register side and small shifter of the serial peripheral select block
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module sdr_top #(
	parameter int DW = 8,
	parameter int HALF_DIV = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sck_in,
	input wire logic nss_in,
	input wire logic miso_in,
	input wire logic mosi_in,
	output logic sck_out,
	output logic mosi_out,
	output logic miso_out,
	output logic [3:0] periph_select_n,
	input wire logic dma_rx_zero,
	input wire logic dma_rx_next_zero,
	input wire logic dma_rx_cnt_wr,
	input wire logic dma_tx_zero,
	input wire logic dma_tx_next_zero,
	input wire logic dma_tx_cnt_wr,
	output logic irq
);
	sdr_pin_if pins ();
	sdr_pin_sync u_sync (
		.clk(clk),
		.rst(rst),
		.pin_in({mosi_in, miso_in, nss_in, sck_in}),
		.pins(pins)
	);

	function automatic logic [3:0] sel_decode(input logic [3:0] c, input logic dec);
		if (dec)
			return c;
		else if (!c[0])
			return 4'he;
		else if (!c[1])
			return 4'hd;
		else if (!c[2])
			return 4'hb;
		else if (!c[3])
			return 4'h7;
		else
			return sdr_pkg::SEL_NONE;
	endfunction

	function automatic logic [31:0] lanes(input logic [3:0] s);
		logic [31:0] m;
		m = 32'h0;
		for (int i = 0; i < 4; i++)
			m[i*8 +: 8] = {8{s[i]}};
		return m;
	endfunction

	////////////////////////////////////////////////////////////////
	logic ack_r;
	logic [31:0] dat_r;
	logic [31:0] mode_r;
	logic en_r;
	logic tx_empty_flag_r;
	logic rxf_r;
	logic mode_fault_flag_r;
	logic ovr_r;
	logic rxend_r;
	logic txend_r;
	logic rxbuf_r;
	logic txbuf_r;
	logic slave_select_rise_r;
	logic idle_r;
	logic [9:0] mask_r;
	logic irq_r;
	logic [DW-1:0] tx_word_r;
	logic [3:0] tx_code_r;
	logic tx_rel_r;
	logic [DW-1:0] rx_word_r;
	logic [3:0] rx_code_r;
	logic rx_load_r;
	logic [DW-1:0] rx_cap_r;
	logic [3:0] rx_cap_code_r;
	sdr_pkg::sdr_state_t state_r;
	logic [DW-1:0] shift_r;
	logic [7:0] bit_cnt_r;
	logic [15:0] div_cnt_r;
	logic [7:0] gap_cnt_r;
	logic [3:0] sel_n_r;
	logic [3:0] target_r;
	logic rel_r;
	logic sck_r;
	logic mosi_r;
	logic miso_r;

	logic acc;
	logic wr;
	logic rd;
	logic [31:0] wd;
	logic [31:0] status_w;
	logic [31:0] rdata;
	logic mstr;
	logic pending;
	logic tx_take;
	logic [3:0] code_w;
	logic [7:0] gap_w;

	assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr = acc & wb_we_i;
	assign rd = acc & ~wb_we_i;
	assign wd = wb_dat_i & lanes(wb_sel_i);
	assign mstr = mode_r[sdr_pkg::MR_MSTR];
	assign pending = en_r & ~tx_empty_flag_r;

	assign status_w = {15'h0, en_r, 6'h0, idle_r, slave_select_rise_r,
		txbuf_r, rxbuf_r, txend_r, rxend_r, ovr_r, mode_fault_flag_r, tx_empty_flag_r, rxf_r};

	// variable selection uses the code written with each character
	assign code_w = mode_r[sdr_pkg::MR_PS] ? tx_code_r : mode_r[sdr_pkg::CODE_LO +: 4];
	assign gap_w = (mode_r[sdr_pkg::GAP_LO +: 8] <= sdr_pkg::GAP_MIN) ?
		sdr_pkg::GAP_MIN : mode_r[sdr_pkg::GAP_LO +: 8];

	// the shifter takes a pending character when it can start or chain one
	always_comb begin
		tx_take = 1'b0;
		if (pending) begin
			if (mstr)
				tx_take = (state_r == sdr_pkg::S_IDLE);
			else
				tx_take = pins.fall[sdr_pkg::PIN_NSS] | (pins.rise[sdr_pkg::PIN_SCK] &
					~pins.lvl[sdr_pkg::PIN_NSS] && bit_cnt_r == 8'(DW - 1));
		end
	end

	////////////////////////////////////////////////////////////////
	// bus slave: one wait state, ack drops the cycle after it rose
	always_comb begin
		case (wb_adr_i)
			sdr_pkg::OFF_MODE: rdata = mode_r;
			sdr_pkg::OFF_RXD: rdata = {12'h0, rx_code_r, 16'(rx_word_r)};
			sdr_pkg::OFF_STAT: rdata = status_w;
			sdr_pkg::OFF_IMR: rdata = {22'h0, mask_r};
			default: rdata = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end else begin
			ack_r <= acc;
			dat_r <= rd ? rdata : 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			mode_r <= 32'h0;
		else if (wr && wb_adr_i == sdr_pkg::OFF_MODE)
			mode_r <= wd & sdr_pkg::MODE_USED;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_word_r <= '0;
			tx_code_r <= sdr_pkg::SEL_NONE;
			tx_rel_r <= 1'b0;
		end else if (wr && wb_adr_i == sdr_pkg::OFF_TXD) begin
			tx_word_r <= wd[DW-1:0];
			tx_code_r <= wd[sdr_pkg::CODE_LO +: 4];
			tx_rel_r <= wd[sdr_pkg::REL_BIT] & mode_r[sdr_pkg::MR_PS];
		end
	end

	////////////////////////////////////////////////////////////////
	// enable, fault and transmit-empty state
	always_ff @(posedge clk) begin
		if (rst)
			en_r <= 1'b0;
		else if (mode_fault_flag_r)
			en_r <= 1'b0;
		else if (wr && wb_adr_i == sdr_pkg::OFF_CTRL && (wd[sdr_pkg::CTRL_EN] | wd[sdr_pkg::CTRL_DIS]))
			en_r <= ~wd[sdr_pkg::CTRL_DIS];
	end

	always_ff @(posedge clk) begin
		if (rst)
			tx_empty_flag_r <= 1'b0;
		else if (mode_fault_flag_r || (wr && wb_adr_i == sdr_pkg::OFF_CTRL && wd[sdr_pkg::CTRL_DIS]))
			tx_empty_flag_r <= 1'b0;
		else if (wr && wb_adr_i == sdr_pkg::OFF_CTRL && wd[sdr_pkg::CTRL_EN])
			tx_empty_flag_r <= 1'b1;
		else if (wr && wb_adr_i == sdr_pkg::OFF_TXD)
			tx_empty_flag_r <= 1'b0;
		else if (tx_take)
			tx_empty_flag_r <= 1'b1;
	end

	// a master sees its select input pulled low by another master
	always_ff @(posedge clk) begin
		if (rst)
			mode_fault_flag_r <= 1'b0;
		else if (en_r && mstr && !mode_r[sdr_pkg::MR_MODFDIS] && !pins.lvl[sdr_pkg::PIN_NSS])
			mode_fault_flag_r <= 1'b1;
		else if (rd && wb_adr_i == sdr_pkg::OFF_STAT)
			mode_fault_flag_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// receive side: loads always land, flags set over clears except idle, where a transmit write wins
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_word_r <= '0;
			rx_code_r <= 4'h0;
		end else if (rx_load_r) begin
			rx_word_r <= rx_cap_r;
			rx_code_r <= rx_cap_code_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			rxf_r <= 1'b0;
		else if (rx_load_r)
			rxf_r <= 1'b1;
		else if (rd && wb_adr_i == sdr_pkg::OFF_RXD)
			rxf_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst)
			ovr_r <= 1'b0;
		else if (rx_load_r && rxf_r && !(rd && wb_adr_i == sdr_pkg::OFF_RXD))
			ovr_r <= 1'b1;
		else if (rd && wb_adr_i == sdr_pkg::OFF_STAT)
			ovr_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst)
			slave_select_rise_r <= 1'b0;
		else if (pins.rise[sdr_pkg::PIN_NSS])
			slave_select_rise_r <= 1'b1;
		else if (rd && wb_adr_i == sdr_pkg::OFF_STAT)
			slave_select_rise_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rxend_r <= sdr_pkg::STAT_RST[4];
			txend_r <= sdr_pkg::STAT_RST[5];
			rxbuf_r <= sdr_pkg::STAT_RST[6];
			txbuf_r <= sdr_pkg::STAT_RST[7];
		end else begin
			rxend_r <= dma_rx_zero | (rxend_r & ~dma_rx_cnt_wr);
			txend_r <= dma_tx_zero | (txend_r & ~dma_tx_cnt_wr);
			rxbuf_r <= dma_rx_zero & dma_rx_next_zero;
			txbuf_r <= dma_tx_zero & dma_tx_next_zero;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			idle_r <= 1'b0;
		else if (wr && wb_adr_i == sdr_pkg::OFF_TXD)
			idle_r <= 1'b0;
		else if (en_r && !pending && state_r == sdr_pkg::S_IDLE && bit_cnt_r == 8'h0)
			idle_r <= 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// interrupt mask and line
	always_ff @(posedge clk) begin
		if (rst)
			mask_r <= 10'h0;
		else if (wr && wb_adr_i == sdr_pkg::OFF_IER)
			mask_r <= mask_r | wd[sdr_pkg::NSRC-1:0];
		else if (wr && wb_adr_i == sdr_pkg::OFF_IDR)
			mask_r <= mask_r & ~wd[sdr_pkg::NSRC-1:0];
	end

	always_ff @(posedge clk) begin
		if (rst)
			irq_r <= 1'b0;
		else
			irq_r <= |(status_w[sdr_pkg::NSRC-1:0] & mask_r);
	end

	////////////////////////////////////////////////////////////////
	// shifter: master drives select, clock and data; slave follows pins
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= sdr_pkg::S_IDLE;
			shift_r <= '0;
			bit_cnt_r <= 8'h0;
			div_cnt_r <= 16'h0;
			gap_cnt_r <= 8'h0;
			sel_n_r <= sdr_pkg::SEL_NONE;
			target_r <= sdr_pkg::SEL_NONE;
			rel_r <= 1'b0;
			sck_r <= 1'b0;
			mosi_r <= 1'b0;
			miso_r <= 1'b0;
			rx_load_r <= 1'b0;
			rx_cap_r <= '0;
			rx_cap_code_r <= 4'h0;
		end else begin
			rx_load_r <= 1'b0;
			if (!mstr) begin
				// slave: pcs field reads zero, select lines stay idle
				state_r <= sdr_pkg::S_IDLE;
				sel_n_r <= sdr_pkg::SEL_NONE;
				sck_r <= 1'b0;
				if (pins.fall[sdr_pkg::PIN_NSS]) begin
					bit_cnt_r <= 8'h0;
					miso_r <= tx_take ? tx_word_r[DW-1] : shift_r[DW-1];
					if (tx_take)
						shift_r <= tx_word_r;
				end else if (pins.rise[sdr_pkg::PIN_SCK] && !pins.lvl[sdr_pkg::PIN_NSS]) begin
					if (bit_cnt_r == 8'(DW - 1)) begin
						bit_cnt_r <= 8'h0;
						rx_load_r <= en_r;
						rx_cap_r <= {shift_r[DW-2:0], pins.lvl[sdr_pkg::PIN_MOSI]};
						rx_cap_code_r <= 4'h0;
						shift_r <= tx_take ? tx_word_r : {shift_r[DW-2:0], pins.lvl[sdr_pkg::PIN_MOSI]};
					end else begin
						bit_cnt_r <= bit_cnt_r + 8'h1;
						shift_r <= {shift_r[DW-2:0], pins.lvl[sdr_pkg::PIN_MOSI]};
					end
				end else if (pins.fall[sdr_pkg::PIN_SCK]) begin
					miso_r <= shift_r[DW-1];
				end
			end else begin
				case (state_r)
					sdr_pkg::S_IDLE: begin
						if (tx_take) begin
							shift_r <= tx_word_r;
							mosi_r <= tx_word_r[DW-1];
							rel_r <= tx_rel_r;
							bit_cnt_r <= 8'h0;
							div_cnt_r <= 16'(HALF_DIV - 1);
							target_r <= sel_decode(code_w, mode_r[sdr_pkg::MR_DEC]);
							if (sel_n_r != sel_decode(code_w, mode_r[sdr_pkg::MR_DEC])) begin
								sel_n_r <= sdr_pkg::SEL_NONE;
								gap_cnt_r <= gap_w;
								state_r <= sdr_pkg::S_GAP;
							end else begin
								state_r <= sdr_pkg::S_SHIFT;
							end
						end
					end
					sdr_pkg::S_GAP: begin
						// every select stays high for the whole gap
						if (gap_cnt_r <= 8'h1) begin
							sel_n_r <= target_r;
							state_r <= sdr_pkg::S_SHIFT;
						end
						gap_cnt_r <= gap_cnt_r - 8'h1;
					end
					sdr_pkg::S_SHIFT: begin
						if (div_cnt_r == 16'h0) begin
							div_cnt_r <= 16'(HALF_DIV - 1);
							sck_r <= ~sck_r;
							if (!sck_r) begin
								shift_r <= {shift_r[DW-2:0], pins.lvl[sdr_pkg::PIN_MISO]};
								bit_cnt_r <= bit_cnt_r + 8'h1;
							end else if (bit_cnt_r == 8'(DW)) begin
								rx_load_r <= 1'b1;
								rx_cap_r <= shift_r;
								rx_cap_code_r <= sel_n_r;
								state_r <= sdr_pkg::S_DONE;
							end else begin
								mosi_r <= shift_r[DW-1];
							end
						end else begin
							div_cnt_r <= div_cnt_r - 16'h1;
						end
					end
					sdr_pkg::S_DONE: begin
						bit_cnt_r <= 8'h0;
						if (rel_r || !mode_r[sdr_pkg::MR_HOLD])
							sel_n_r <= sdr_pkg::SEL_NONE;
						state_r <= sdr_pkg::S_IDLE;
					end
					default: state_r <= sdr_pkg::S_IDLE;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign sck_out = sck_r;
	assign mosi_out = mosi_r;
	assign miso_out = miso_r;
	assign periph_select_n = sel_n_r;
	assign irq = irq_r;

	////////////////////////////////////////////////////////////////
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);

	gap_min_a: assert property ($rose(state_r == sdr_pkg::S_GAP) |-> gap_cnt_r >= 8'h6)
		else $error("select gap shorter than six cycles");
	gap_quiet_a: assert property (state_r == sdr_pkg::S_GAP |-> periph_select_n == 4'hf)
		else $error("select active during gap");
	rx_upper_a: assert property (wb_ack_o && $past(wb_adr_i) == sdr_pkg::OFF_RXD |-> wb_dat_o[31:20] == 12'h0)
		else $error("receive upper bits not zero");
	slave_code_a: assert property (rx_load_r && !mstr |=> rx_code_r == 4'h0)
		else $error("slave receive code not zero");
	one_sel_a: assert property (!mode_r[sdr_pkg::MR_DEC] |-> $countones(~periph_select_n) <= 1)
		else $error("more than one select active");
	release_a: assert property (state_r == sdr_pkg::S_DONE && rel_r |=> periph_select_n == 4'hf)
		else $error("select kept after release");
	rx_full_a: assert property (rx_load_r |=> rxf_r)
		else $error("receive full not set on load");
	tx_empty_flag_wr_a: assert property (wr && wb_adr_i == sdr_pkg::OFF_TXD |=> !tx_empty_flag_r ##1 1'b1)
		else $error("transmit empty not cleared by write");
	ovr_set_a: assert property (rx_load_r && rxf_r && !rd |=> ovr_r)
		else $error("overrun not flagged");
	ier_set_a: assert property (wr && wb_adr_i == sdr_pkg::OFF_IER |=>
		(mask_r & $past(wd[9:0])) == $past(wd[9:0]))
		else $error("enable write did not set mask");
	idr_clr_a: assert property (wr && wb_adr_i == sdr_pkg::OFF_IDR |=> (mask_r & $past(wd[9:0])) == 10'h0)
		else $error("disable write did not clear mask");
	irq_line_a: assert property (|(status_w[9:0] & mask_r) |=> irq)
		else $error("interrupt missing for enabled flag");
endmodule // sdr_top
`default_nettype wire

// >>> src/sdr_pkg.sv
// constants and types of the serial select, data and status register block
// What this block does
// - select gap waits setting, six cycles minimum
// - received word right-justified, upper bits zero
// - master captures select levels; slave reads zero
// - transmit word taken from low bits
// - direct select wiring: first clear code bit wins
// - decode mode drives code straight out
// - release bit deasserts select after character, in variable selection only
// - receive full sets on load, clears on read
// - transmit empty: write clears, load sets, enable
// - mode fault sticky until status read
// - second unread load sets overrun flag
// - dma counter reached zero since last write
// - buffers done when both counters zero
// - select input rising edge sets sticky flag
// - idle flag: write clears, empty path sets
// - enable state bit mirrors interface enable
// - enable register sets mask bits on ones
// - disable register clears mask bits on ones
// - mask register reads enabled sources
// - fixed selection takes code from mode register
// - decode mode allows fifteen external selects
package sdr_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_RXD = 8'h08;
	localparam logic [7:0] OFF_TXD = 8'h0c;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_IER = 8'h14;
	localparam logic [7:0] OFF_IDR = 8'h18;
	localparam logic [7:0] OFF_IMR = 8'h1c;
	localparam int CTRL_EN = 0;
	localparam int CTRL_DIS = 1;
	localparam int REL_BIT = 24;
	localparam int MR_MSTR = 0;
	localparam int MR_PS = 1;
	localparam int MR_DEC = 2;
	localparam int MR_MODFDIS = 4;
	localparam int MR_HOLD = 8;
	localparam int CODE_LO = 16;
	localparam int GAP_LO = 24;
	localparam int ST_EN = 16;
	localparam int NSRC = 10;
	localparam logic [31:0] MODE_USED = 32'hff0f0117;
	localparam logic [31:0] STAT_RST = 32'h000000f0;
	localparam logic [7:0] GAP_MIN = 8'h06;
	localparam int PIN_SCK = 0;
	localparam int PIN_NSS = 1;
	localparam int PIN_MISO = 2;
	localparam int PIN_MOSI = 3;
	localparam logic [3:0] PIN_RST = 4'h2;
	localparam logic [3:0] SEL_NONE = 4'hf;
	typedef enum logic [1:0] {S_IDLE, S_GAP, S_SHIFT, S_DONE} sdr_state_t;
endpackage

// >>> src/sdr_pin_if.sv
// filtered pin levels and edges passed from the synchroniser to the block
`timescale 1ns/10ps
`default_nettype none
interface sdr_pin_if;
	logic [3:0] lvl;
	logic [3:0] rise;
	logic [3:0] fall;
	modport src (output lvl, output rise, output fall);
	modport snk (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// >>> src/sdr_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none
module sdr_pin_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] pin_in,
	sdr_pin_if.src pins
);
	logic [3:0] s1_r;
	logic [3:0] s2_r;
	logic [3:0] s3_r;
	logic [3:0] lvl_r;
	logic [3:0] prev_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= sdr_pkg::PIN_RST;
			s2_r <= sdr_pkg::PIN_RST;
			s3_r <= sdr_pkg::PIN_RST;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a level only counts once the last two stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			lvl_r <= sdr_pkg::PIN_RST;
			prev_r <= sdr_pkg::PIN_RST;
		end else begin
			lvl_r <= (s3_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
			prev_r <= lvl_r;
		end
	end

	assign pins.lvl = lvl_r;
	assign pins.rise = lvl_r & ~prev_r;
	assign pins.fall = ~lvl_r & prev_r;
endmodule // sdr_pin_sync
`default_nettype wire

// >>> verification/sdr_periph_model.sv
// stand-in for a serial peripheral: replies one byte per character, records what it hears
`timescale 1ns/10ps
`default_nettype none
module sdr_periph_model (
	input wire logic [3:0] sel_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic [7:0] reply,
	output logic miso,
	output logic [7:0] got,
	output int nchar
);
	int nb = 0;
	int ix = 0;
	logic [7:0] rx = 8'h00;
	initial begin
		miso = 1'b0;
		got = 8'h00;
		nchar = 0;
	end
	// a new select always starts a fresh character
	always @(sel_n) begin
		nb = 0;
		ix = 0;
	end
	// data moves on the falling edge, the master samples on the rising one
	always @(negedge sck) begin
		if (nb == 8)
			nb = 0;
		ix = nb;
	end
	always @(posedge sck) begin
		if (sel_n != 4'hf) begin
			rx = {rx[6:0], mosi};
			nb = nb + 1;
			if (nb == 8) begin
				got = rx;
				nchar = nchar + 1;
			end
		end
	end
	// a released line must not keep its last level, or a stale bit could pass
	always @(sel_n or ix or reply) begin
		if (sel_n != 4'hf)
			miso = reply[3'd7 - ix[2:0]];
		else
			miso = ~miso;
	end
endmodule // sdr_periph_model
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench of the select, data and status register block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, sck_out, mosi_out, miso_out, irq, miso_in;
	logic [3:0] periph_select_n;
	logic sck_in = 1'b0, nss_in = 1'b1, mosi_in = 1'b0;
	logic rxz = 1'b1, rxnz = 1'b1, rxw = 1'b0, txz = 1'b1, txnz = 1'b1, txw = 1'b0;
	logic [7:0] reply = 8'h00, got, r, ts;
	logic [31:0] q_rd[$], q_msk[$], mon_e, mon_m;
	logic [3:0] q_sel[$];
	logic [7:0] q_mo[$];
	int q_gap[$];
	int seed = 3665, num_errors = 0, samples_checked = 0, cycles = 0, hi_run = 0, nchar;
	logic was_hi = 1'b1;

	sdr_top #(.DW(8), .HALF_DIV(5)) DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .sck_in(sck_in), .nss_in(nss_in), .miso_in(miso_in), .mosi_in(mosi_in),
		.sck_out(sck_out), .mosi_out(mosi_out), .miso_out(miso_out), .periph_select_n(periph_select_n),
		.dma_rx_zero(rxz), .dma_rx_next_zero(rxnz), .dma_rx_cnt_wr(rxw), .dma_tx_zero(txz),
		.dma_tx_next_zero(txnz), .dma_tx_cnt_wr(txw), .irq(irq));
	sdr_periph_model peer (.sel_n(periph_select_n), .sck(sck_out), .mosi(mosi_out), .reply(reply),
		.miso(miso_in), .got(got), .nchar(nchar));

	initial begin
		forever #10 clk = ~clk;
	end

	task automatic conclude;
		if (num_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic compare(input logic [31:0] g, input logic [31:0] e, input string what);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, g, e);
		end
	endtask

	// classic single cycle; waits on ack, the global cycle ceiling bounds a hang
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
			@(posedge clk);
		while (wb_ack_o !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	// a zero mask only consumes the answer, as for the clearing read of a stale word
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		q_rd.push_back(e);
		q_msk.push_back(m);
		wb(1'b0, a, 32'h00000000);
	endtask

	// one master character: note select, gap and byte, then wait for the peer to finish
	task automatic xfer(input logic [3:0] code, input logic [3:0] sn, input int gap, input logic last,
		output logic [7:0] rep);
		logic [7:0] tx;
		int n;
		n = nchar;
		tx = 8'($random(seed));
		rep = 8'($random(seed));
		reply <= rep;
		q_sel.push_back(sn);
		q_gap.push_back(gap);
		q_mo.push_back(tx);
		wr(sdr_pkg::OFF_TXD, {7'h00, last, 4'h0, code, 8'h00, tx});
		while (nchar == n)
			@(posedge clk);
		repeat (20) @(posedge clk);
	endtask

	always @(posedge clk) begin
		if (wb_ack_o === 1'b1 && we === 1'b0 && q_rd.size() > 0) begin
			mon_e = q_rd.pop_front();
			mon_m = q_msk.pop_front();
			if (mon_m != 32'h00000000)
				compare(wb_dat_o & mon_m, mon_e, "register read");
		end
	end

	// every activation of a select must be one that was asked for, after a full gap
	always @(posedge clk) begin
		if (!rst && periph_select_n !== 4'hf && was_hi) begin
			if (q_sel.size() == 0)
				compare({28'h0, periph_select_n}, 32'h0000000f, "unexpected select");
			else begin
				compare({28'h0, periph_select_n}, {28'h0, q_sel.pop_front()}, "select lines");
				compare({31'h0, hi_run >= q_gap.pop_front()}, 32'h1, "select gap");
			end
		end
		was_hi <= (periph_select_n === 4'hf);
		hi_run <= (periph_select_n === 4'hf) ? hi_run + 1 : 0;
	end

	always @(nchar) begin
		if (nchar > 0 && q_mo.size() > 0)
			compare({24'h0, got}, {24'h0, q_mo.pop_front()}, "serial byte");
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(sdr_pkg::OFF_STAT, sdr_pkg::STAT_RST, '1);
		rd(sdr_pkg::OFF_IMR, 32'h0, '1);
		rd(8'h40, 32'h0, '1);
		wr(sdr_pkg::OFF_IER, 32'hffffffff);
		rd(sdr_pkg::OFF_IMR, 32'h000003ff, '1);
		wr(sdr_pkg::OFF_IDR, 32'h00000155);
		rd(sdr_pkg::OFF_IMR, 32'h000002aa, '1);
		wr(sdr_pkg::OFF_IDR, 32'hffffffff);
		wr(sdr_pkg::OFF_CTRL, 32'h1);
		rd(sdr_pkg::OFF_STAT, 32'h000102f2, '1);
		// hold selects so each change goes through the gap, not through idle
		wr(sdr_pkg::OFF_MODE, 32'h03000113);
		xfer(4'h0, 4'he, 6, 1'b0, r);
		xfer(4'h1, 4'hd, 6, 1'b0, r);
		rd(sdr_pkg::OFF_STAT, 32'h0000020b, 32'h0000020f);
		rd(sdr_pkg::OFF_RXD, {12'h0, 4'hd, 8'h0, r}, '1);
		rd(sdr_pkg::OFF_STAT, 32'h0, 32'h00000009);
		wr(sdr_pkg::OFF_MODE, 32'h0a000113);
		xfer(4'h3, 4'hb, 10, 1'b0, r);
		rd(sdr_pkg::OFF_RXD, {12'h0, 4'hb, 8'h0, r}, '1);
		xfer(4'h7, 4'h7, 10, 1'b1, r);
		rd(sdr_pkg::OFF_RXD, {24'h0, r}, 32'h0000ffff);
		compare({28'h0, periph_select_n}, 32'h0000000f, "release after last");
		wr(sdr_pkg::OFF_MODE, 32'h03090015);
		xfer(4'h0, 4'h9, 6, 1'b0, r);
		rd(sdr_pkg::OFF_RXD, 32'h0, 32'h0);
		wr(sdr_pkg::OFF_MODE, 32'h00000001);
		nss_in <= 1'b0;
		repeat (10) @(posedge clk);
		rd(sdr_pkg::OFF_STAT, 32'h00000004, 32'h00010006);
		nss_in <= 1'b1;
		repeat (10) @(posedge clk);
		rd(sdr_pkg::OFF_STAT, 32'h00000100, 32'h00000104);
		rd(sdr_pkg::OFF_STAT, 32'h0, 32'h00000104);
		// a character written while disabled must be dropped, not sent on enable
		wr(sdr_pkg::OFF_TXD, 32'h0000005a);
		rd(sdr_pkg::OFF_STAT, 32'h0, 32'h00010002);
		wr(sdr_pkg::OFF_CTRL, 32'h1);
		rd(sdr_pkg::OFF_STAT, 32'h00010002, 32'h00010002);
		repeat (40) @(posedge clk);
		wr(sdr_pkg::OFF_MODE, 32'h0);
		// slave answer: the pending word goes out from the select fall on
		ts = 8'($random(seed));
		wr(sdr_pkg::OFF_TXD, {24'h0, ts});
		r = 8'($random(seed));
		nss_in <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = 7; i >= 0; i--) begin
			sck_in <= 1'b0;
			mosi_in <= r[i];
			repeat (4) @(posedge clk);
			sck_in <= 1'b1;
			repeat (4) @(posedge clk);
			compare({31'h0, miso_out}, {31'h0, ts[i]}, "slave out bit");
		end
		sck_in <= 1'b0;
		repeat (8) @(posedge clk);
		nss_in <= 1'b1;
		repeat (10) @(posedge clk);
		rd(sdr_pkg::OFF_RXD, {24'h0, r}, '1);
		rd(sdr_pkg::OFF_STAT, 32'h00000100, 32'h00000100);
		wr(sdr_pkg::OFF_IER, 32'h00000010);
		rxz <= 1'b0;
		txnz <= 1'b0;
		rxw <= 1'b1;
		txw <= 1'b1;
		@(posedge clk);
		rxw <= 1'b0;
		txw <= 1'b0;
		repeat (4) @(posedge clk);
		rd(sdr_pkg::OFF_STAT, 32'h00000020, 32'h000000f0);
		compare({31'h0, irq}, 32'h0, "irq low");
		rxz <= 1'b1;
		txnz <= 1'b1;
		repeat (4) @(posedge clk);
		rd(sdr_pkg::OFF_STAT, 32'h000000f0, 32'h000000f0);
		compare({31'h0, irq}, 32'h1, "irq high");
		conclude();
	end
endmodule // testbench
`default_nettype wire
